// ===== rsc_consts.svh
// Constants for the real-time clock status and reset control block.
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH
`define RSC_ADDR_W          4
`define RSC_ADDR_CTRL1      4'h0
`define RSC_ADDR_CTRL2      4'h1
`define RSC_ADDR_SECONDS    4'h2
`define RSC_ADDR_MINUTES    4'h3
`define RSC_ADDR_HOURS      4'h4
`define RSC_ADDR_DAYS       4'h5
`define RSC_ADDR_WEEKDAYS   4'h6
`define RSC_ADDR_MONTHS     4'h7
`define RSC_ADDR_YEARS      4'h8
`define RSC_ADDR_AL_MINUTE  4'h9
`define RSC_ADDR_AL_HOUR    4'hA
`define RSC_ADDR_AL_DAY     4'hB
`define RSC_ADDR_AL_WEEKDAY 4'hC
`define RSC_ADDR_OFFSET     4'hD
`define RSC_ADDR_TIMER_CLK  4'hE
`define RSC_ADDR_COUNTDOWN  4'hF
`define RSC_MASK_SEVEN      8'h7F
`define RSC_MASK_SIX        8'h3F
`define RSC_MASK_FIVE       8'h1F
`define RSC_MASK_THREE      8'h07
`define RSC_MASK_ALL        8'hFF
`define RSC_SOFT_RESET_CODE 8'h58
`define RSC_CTRL1_KEEP      8'hA6
`define RSC_CTRL2_WRITE     8'hD3
`define RSC_CTRL2_FLAGS     8'h2C
`define RSC_TCC_KEEP        8'h7B
`define RSC_TCC_RESET       8'h03
`define RSC_ALARM_OFF_RESET 4'hF
`define RSC_CLK_OFF_CODE    3'h7
`define RSC_C1_STOP         5
`define RSC_C1_HOUR12       2
`define RSC_C1_CORR_EN      1
`define RSC_C2_LONG_EN      7
`define RSC_C2_SHORT_EN     6
`define RSC_C2_TICK_F       5
`define RSC_C2_PULSE        4
`define RSC_C2_ALARM_F      3
`define RSC_C2_COUNT_F      2
`define RSC_C2_ALARM_EN     1
`define RSC_C2_COUNT_EN     0
`define RSC_HALT_BIT        7
`define RSC_CMD_READ_BIT    6
`define RSC_OSC_SETTLE_MS   500
`define RSC_CLOCK_KHZ       125000
`define RSC_SETTLE_CYCLES   (`RSC_OSC_SETTLE_MS * `RSC_CLOCK_KHZ)
`define RSC_SETTLE_CNT_W    26
`endif

// ===== rsc_pkg.sv
// Types shared by the real-time clock status and reset control block.
package rsc_pkg;
`include "rsc_consts.svh"
  typedef enum logic [1:0] {LINK_CMD, LINK_WRITE, LINK_READ} rsc_link_phase_type;

  typedef struct packed {
    rsc_link_phase_type phase;
    logic [2:0]         bitCnt;
    logic [6:0]         shiftIn;
    logic [3:0]         addr;
    logic [3:0]         wrAddr;
    logic [7:0]         wrData;
    logic               wrReq;
    logic               rdReq;
    logic [7:0]         shiftOut;
    logic               outEn;
  } rsc_link_state_type;

  typedef struct packed {
    logic [2:0]                     wrSync;
    logic [2:0]                     rdSync;
    logic [1:0]                     oscSync;
    logic [`RSC_SETTLE_CNT_W-1:0]   settleCnt;
    logic                           settled;
    logic [7:0]                     ctrl1;
    logic [7:0]                     ctrl2;
    logic                           oscHalt;
    logic [3:0]                     alarmOff;
    logic [7:0]                     offset;
    logic [7:0]                     tcc;
    logic                           clkOutOn;
    logic                           irqN;
    logic                           memRdValid;
    logic [7:0]                     rdData;
  } rsc_core_state_type;
endpackage

// ===== rsc_reg_mem.sv
// Register store for the bits that no reset touches.
`timescale 1ns/10ps
module rsc_reg_mem #(
  parameter int AW = 4,
  parameter int DW = 8
) (
  input  wire logic          clock,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData
);
  typedef struct packed {
    logic [2**AW-1:0][DW-1:0] cells;
    logic [DW-1:0]            rdData;
  } rsc_mem_state_type;

  rsc_mem_state_type memReg;
  rsc_mem_state_type memNext;

  // Cells have no reset so their contents survive every reset; read data is registered.
  always_comb
  begin
    memNext = memReg;
    if (wrEn)
    begin
      memNext.cells[wrAddr] = wrData;
    end
    memNext.rdData = memReg.cells[rdAddr];
  end

  // Registers the whole store.
  always_ff @(posedge clock)
  begin
    memReg <= memNext;
  end

  assign rdData = memReg.rdData;
endmodule

// ===== rsc_spi_link.sv
// Serial link engine running on the host's serial clock.
`timescale 1ns/10ps
`include "rsc_consts.svh"
module rsc_spi_link
  import rsc_pkg::*;
(
  input  wire logic       sclk,
  input  wire logic       chipEnable,
  input  wire logic       sdi,
  input  wire logic [7:0] rdDataIn,
  output logic      [3:0] rdAddr,
  output logic            rdReq,
  output logic      [3:0] wrAddr,
  output logic      [7:0] wrData,
  output logic            wrReq,
  output logic            sdo,
  output logic            sdoOe
);
  rsc_link_state_type linkReg;
  rsc_link_state_type linkNext;

  // Command byte picks direction and start address; data bytes auto-increment the address.
  always_comb
  begin
    linkNext         = linkReg;
    linkNext.rdReq   = 1'b0;
    linkNext.wrReq   = 1'b0;
    linkNext.bitCnt  = linkReg.bitCnt + 3'h1;
    linkNext.shiftIn = {linkReg.shiftIn[5:0], sdi};
    unique case (linkReg.phase)
      LINK_CMD:
        if (linkReg.bitCnt == 3'h7)
        begin
          linkNext.addr = {linkReg.shiftIn[2:0], sdi};
          // At the eighth edge the shifter holds command bits 7 to 1, one place lower.
          if (linkReg.shiftIn[`RSC_CMD_READ_BIT - 1])
          begin
            linkNext.phase = LINK_READ;
            linkNext.rdReq = 1'b1;
          end
          else
          begin
            linkNext.phase = LINK_WRITE;
          end
        end
      LINK_WRITE:
        if (linkReg.bitCnt == 3'h7)
        begin
          linkNext.wrAddr = linkReg.addr;
          linkNext.wrData = {linkReg.shiftIn, sdi};
          linkNext.wrReq  = 1'b1;
          linkNext.addr   = linkReg.addr + 4'h1;
        end
      LINK_READ:
      begin
        // The next byte is requested one bit into the current one, so each request rises anew.
        linkNext.rdReq = (linkReg.bitCnt == 3'h1);
        if (linkReg.bitCnt == 3'h0)
        begin
          linkNext.shiftOut = rdDataIn;
          linkNext.outEn    = 1'b1;
          linkNext.addr     = linkReg.addr + 4'h1;
        end
        else
        begin
          linkNext.shiftOut = {linkReg.shiftOut[6:0], 1'b0};
        end
      end
    endcase
  end

  // An inactive chip enable holds the engine in its idle state.
  always_ff @(posedge sclk or negedge chipEnable)
  begin
    if (!chipEnable)
      linkReg <= '0;
    else
      linkReg <= linkNext;
  end

  assign rdAddr = linkReg.addr;
  assign rdReq  = linkReg.rdReq;
  assign wrAddr = linkReg.wrAddr;
  assign wrData = linkReg.wrData;
  assign wrReq  = linkReg.wrReq;
  assign sdo    = linkReg.shiftOut[7];
  assign sdoOe  = linkReg.outEn;
endmodule

// ===== rsc_status_reset_control.sv
// Top of the real-time clock status, interrupt and reset control block.
`timescale 1ns/10ps
`include "rsc_consts.svh"
module rsc_status_reset_control
  import rsc_pkg::*;
#(
  parameter int SETTLE_CYCLES = `RSC_SETTLE_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       sclk,
  input  wire logic       chipEnable,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdoOe,
  input  wire logic       oscRunning,
  input  wire logic       minuteTick,
  input  wire logic       secondTick,
  input  wire logic       alarmMatch,
  input  wire logic       countZero,
  output logic            irqN,
  output logic            oscillatorHaltFlag,
  output logic            clockOutPinEnable,
  output logic      [2:0] clockOutPinSelect,
  output logic            hour12Mode,
  output logic            dividerStop,
  output logic            corrIrqEn,
  output logic      [7:0] offsetWord,
  output logic      [3:0] alarmMatchOff,
  output logic            countEnable,
  output logic      [1:0] countSource
);
  localparam rsc_core_state_type CORE_RESET = '{
    oscHalt:  1'b1,
    alarmOff: `RSC_ALARM_OFF_RESET,
    tcc:      `RSC_TCC_RESET,
    clkOutOn: 1'b1,
    irqN:     1'b1,
    default:  '0
  };
  localparam logic [`RSC_SETTLE_CNT_W-1:0] SETTLE_LAST =
    `RSC_SETTLE_CNT_W'(SETTLE_CYCLES - 1);

  rsc_core_state_type coreReg;
  rsc_core_state_type coreNext;

  logic [3:0] linkRdAddr;
  logic       linkRdReq;
  logic [3:0] linkWrAddr;
  logic [7:0] linkWrData;
  logic       linkWrReq;
  logic [7:0] memRdData;
  logic [7:0] memWrData;
  logic       wrEvent;
  logic       rdEvent;
  logic       oscStopped;
  logic       softReset;
  logic       tickHit;
  logic       countHit;

  // Bits of each address kept in the unreset store; all others read as zero there.
  function automatic logic [7:0] storeMask(input logic [3:0] addr);
    logic [7:0] mask;
    mask = 8'h00;
    unique case (addr)
      `RSC_ADDR_SECONDS, `RSC_ADDR_MINUTES, `RSC_ADDR_AL_MINUTE:  mask = `RSC_MASK_SEVEN;
      `RSC_ADDR_HOURS, `RSC_ADDR_DAYS, `RSC_ADDR_AL_HOUR,
      `RSC_ADDR_AL_DAY:                                          mask = `RSC_MASK_SIX;
      `RSC_ADDR_WEEKDAYS, `RSC_ADDR_AL_WEEKDAY:                  mask = `RSC_MASK_THREE;
      `RSC_ADDR_MONTHS:                                          mask = `RSC_MASK_FIVE;
      `RSC_ADDR_YEARS, `RSC_ADDR_COUNTDOWN:                      mask = `RSC_MASK_ALL;
      default:                                                   mask = 8'h00;
    endcase
    return mask;
  endfunction

  // Serial engine on the host's clock.
  rsc_spi_link u_link (
    .sclk       (sclk),
    .chipEnable (chipEnable),
    .sdi        (sdi),
    .rdDataIn   (coreReg.rdData),
    .rdAddr     (linkRdAddr),
    .rdReq      (linkRdReq),
    .wrAddr     (linkWrAddr),
    .wrData     (linkWrData),
    .wrReq      (linkWrReq),
    .sdo        (sdo),
    .sdoOe      (sdoOe)
  );

  // Time, alarm and countdown value bits.
  rsc_reg_mem #(
    .AW (`RSC_ADDR_W),
    .DW (8)
  ) u_mem (
    .clock  (clock),
    .wrEn   (wrEvent),
    .wrAddr (linkWrAddr),
    .wrData (memWrData),
    .rdAddr (linkRdAddr),
    .rdData (memRdData)
  );

  // Request levels are caught on their rise after two synchroniser stages.
  assign wrEvent    = coreReg.wrSync[1] & ~coreReg.wrSync[2];
  assign rdEvent    = coreReg.rdSync[1] & ~coreReg.rdSync[2];
  assign memWrData  = linkWrData & storeMask(linkWrAddr);
  assign softReset  = wrEvent && (linkWrAddr == `RSC_ADDR_CTRL1)
                      && (linkWrData == `RSC_SOFT_RESET_CODE);
  assign oscStopped = ~coreReg.oscSync[1] | ~coreReg.settled;
  assign tickHit    = (minuteTick & coreReg.ctrl2[`RSC_C2_LONG_EN])
                      | (secondTick & coreReg.ctrl2[`RSC_C2_SHORT_EN]);
  assign countHit   = countZero & coreReg.ctrl2[`RSC_C2_COUNT_EN];

  // Next state: synchronisers, settling timer, register writes, flags and the pin.
  always_comb
  begin
    coreNext            = coreReg;
    coreNext.wrSync     = {coreReg.wrSync[1:0], linkWrReq};
    coreNext.rdSync     = {coreReg.rdSync[1:0], linkRdReq};
    coreNext.oscSync    = {coreReg.oscSync[0], oscRunning};
    coreNext.memRdValid = rdEvent;

    // The oscillator counts as stopped until the settling interval has run out.
    if (!coreReg.settled)
    begin
      if (coreReg.settleCnt == SETTLE_LAST)
        coreNext.settled = 1'b1;
      else
        coreNext.settleCnt = coreReg.settleCnt + `RSC_SETTLE_CNT_W'(1);
    end

    // Read data merges reset-held bits with the unreset store.
    if (coreReg.memRdValid)
    begin
      unique case (linkRdAddr)
        `RSC_ADDR_CTRL1:      coreNext.rdData = coreReg.ctrl1;
        `RSC_ADDR_CTRL2:      coreNext.rdData = coreReg.ctrl2;
        `RSC_ADDR_SECONDS:    coreNext.rdData = {coreReg.oscHalt, memRdData[6:0]};
        `RSC_ADDR_AL_MINUTE:  coreNext.rdData = {coreReg.alarmOff[0], memRdData[6:0]};
        `RSC_ADDR_AL_HOUR:    coreNext.rdData = {coreReg.alarmOff[1], memRdData[6:0]};
        `RSC_ADDR_AL_DAY:     coreNext.rdData = {coreReg.alarmOff[2], memRdData[6:0]};
        `RSC_ADDR_AL_WEEKDAY: coreNext.rdData = {coreReg.alarmOff[3], memRdData[6:0]};
        `RSC_ADDR_OFFSET:     coreNext.rdData = coreReg.offset;
        `RSC_ADDR_TIMER_CLK:  coreNext.rdData = coreReg.tcc;
        default:              coreNext.rdData = memRdData;
      endcase
    end

    // Ordinary register writes.
    if (wrEvent && !softReset)
    begin
      unique case (linkWrAddr)
        `RSC_ADDR_CTRL1:
          coreNext.ctrl1 = linkWrData & `RSC_CTRL1_KEEP;
        `RSC_ADDR_CTRL2:
          coreNext.ctrl2 = (linkWrData & `RSC_CTRL2_WRITE)
                           | (coreReg.ctrl2 & linkWrData & `RSC_CTRL2_FLAGS);
        `RSC_ADDR_SECONDS:
          coreNext.oscHalt = coreReg.oscHalt & linkWrData[`RSC_HALT_BIT];
        `RSC_ADDR_AL_MINUTE:  coreNext.alarmOff[0] = linkWrData[7];
        `RSC_ADDR_AL_HOUR:    coreNext.alarmOff[1] = linkWrData[7];
        `RSC_ADDR_AL_DAY:     coreNext.alarmOff[2] = linkWrData[7];
        `RSC_ADDR_AL_WEEKDAY: coreNext.alarmOff[3] = linkWrData[7];
        `RSC_ADDR_OFFSET:     coreNext.offset = linkWrData;
        `RSC_ADDR_TIMER_CLK:  coreNext.tcc = linkWrData & `RSC_TCC_KEEP;
        default:
        begin
        end
      endcase
    end

    // Hardware sets win over an ordinary clear written in the same cycle; a soft reset still clears the tick, alarm and countdown flags.
    if (oscStopped)
      coreNext.oscHalt = 1'b1;
    if (tickHit)
      coreNext.ctrl2[`RSC_C2_TICK_F] = 1'b1;
    if (alarmMatch)
      coreNext.ctrl2[`RSC_C2_ALARM_F] = 1'b1;
    if (countZero)
      coreNext.ctrl2[`RSC_C2_COUNT_F] = 1'b1;

    // The reset pattern restores every reset-held bit and is itself not stored.
    if (softReset)
    begin
      coreNext.ctrl1    = 8'h00;
      coreNext.ctrl2    = 8'h00;
      coreNext.oscHalt  = 1'b1;
      coreNext.alarmOff = `RSC_ALARM_OFF_RESET;
      coreNext.offset   = 8'h00;
      coreNext.tcc      = `RSC_TCC_RESET;
    end

    coreNext.clkOutOn = (coreNext.tcc[6:4] != `RSC_CLK_OFF_CODE);

    // Pin follows the enabled flags, or in pulse mode pulses once per timer event.
    if (coreNext.ctrl2[`RSC_C2_PULSE] && !softReset)
      coreNext.irqN = ~(tickHit | countHit
                        | (coreNext.ctrl2[`RSC_C2_ALARM_F]
                           & coreNext.ctrl2[`RSC_C2_ALARM_EN]));
    else
      coreNext.irqN = ~((coreNext.ctrl2[`RSC_C2_TICK_F]
                         & (coreNext.ctrl2[`RSC_C2_LONG_EN] | coreNext.ctrl2[`RSC_C2_SHORT_EN]))
                        | (coreNext.ctrl2[`RSC_C2_COUNT_F] & coreNext.ctrl2[`RSC_C2_COUNT_EN])
                        | (coreNext.ctrl2[`RSC_C2_ALARM_F]
                           & coreNext.ctrl2[`RSC_C2_ALARM_EN]));
  end

  // Power-on reset loads the defaults with the halt flag set.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      coreReg <= CORE_RESET;
    else
      coreReg <= coreNext;
  end

  assign irqN               = coreReg.irqN;
  assign oscillatorHaltFlag = coreReg.oscHalt;
  assign clockOutPinEnable  = coreReg.clkOutOn;
  assign clockOutPinSelect  = coreReg.tcc[6:4];
  assign hour12Mode         = coreReg.ctrl1[`RSC_C1_HOUR12];
  assign dividerStop        = coreReg.ctrl1[`RSC_C1_STOP];
  assign corrIrqEn          = coreReg.ctrl1[`RSC_C1_CORR_EN];
  assign offsetWord         = coreReg.offset;
  assign alarmMatchOff      = coreReg.alarmOff;
  assign countEnable        = coreReg.tcc[3];
  assign countSource        = coreReg.tcc[1:0];

  // Checks of the guarded reset, the halt flag, the tick and alarm flags and the interrupt pin.
  sequence s_soft_write;
    wrEvent && (linkWrAddr == `RSC_ADDR_CTRL1) && (linkWrData == `RSC_SOFT_RESET_CODE);
  endsequence

  sequence s_stray_ctrl1_write;
    wrEvent && (linkWrAddr == `RSC_ADDR_CTRL1) && (linkWrData != `RSC_SOFT_RESET_CODE);
  endsequence

  property p_soft_reset_clears;
    @(posedge clock) disable iff (!rst_n)
    s_soft_write |=> (coreReg.ctrl1 == 8'h00) && (coreReg.ctrl2 == 8'h00) && oscillatorHaltFlag;
  endproperty
  a_soft_reset_clears: assert property (p_soft_reset_clears)
    else $error("Soft reset pattern did not clear the control registers.");

  property p_stray_write_stored;
    @(posedge clock) disable iff (!rst_n)
    s_stray_ctrl1_write
    |=> (coreReg.ctrl1 == ($past(linkWrData) & `RSC_CTRL1_KEEP));
  endproperty
  a_stray_write_stored: assert property (p_stray_write_stored)
    else $error("A non-reset write to control one was not stored as written.");

  property p_pattern_not_stored;
    @(posedge clock) disable iff (!rst_n)
    s_soft_write |=> !hour12Mode && !dividerStop && !corrIrqEn;
  endproperty
  a_pattern_not_stored: assert property (p_pattern_not_stored)
    else $error("Bits of the reset pattern were stored in control one.");

  property p_stop_sets_halt;
    @(posedge clock) disable iff (!rst_n)
    oscStopped |=> oscillatorHaltFlag;
  endproperty
  a_stop_sets_halt: assert property (p_stop_sets_halt)
    else $error("Stopped oscillator did not set the halt flag.");

  property p_halt_sticky;
    @(posedge clock) disable iff (!rst_n)
    oscillatorHaltFlag && !(wrEvent && (linkWrAddr == `RSC_ADDR_SECONDS)
                            && !linkWrData[`RSC_HALT_BIT])
    |=> oscillatorHaltFlag;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky)
    else $error("Halt flag dropped without a clearing write.");

  property p_halt_through_settling;
    @(posedge clock) disable iff (!rst_n)
    !coreReg.settled && (coreReg.settleCnt != SETTLE_LAST) |=> oscillatorHaltFlag [*2];
  endproperty
  a_halt_through_settling: assert property (p_halt_through_settling)
    else $error("Halt flag cleared before the oscillator settled.");

  property p_power_up_halt;
    @(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> oscillatorHaltFlag && !coreReg.settled && irqN;
  endproperty
  a_power_up_halt: assert property (p_power_up_halt)
    else $error("Halt flag not set after power-on reset.");

  property p_reset_clock_out;
    @(posedge clock) disable iff (!rst_n)
    s_soft_write |=> clockOutPinEnable && (clockOutPinSelect == 3'h0);
  endproperty
  a_reset_clock_out: assert property (p_reset_clock_out)
    else $error("Reset did not select the full-rate clock output.");

  property p_reset_hour_mode;
    @(posedge clock) disable iff (!rst_n)
    s_soft_write |=> !hour12Mode [*1];
  endproperty
  a_reset_hour_mode: assert property (p_reset_hour_mode)
    else $error("Reset did not select 24-hour counting.");

  property p_reset_offset;
    @(posedge clock) disable iff (!rst_n)
    s_soft_write |=> (offsetWord == 8'h00);
  endproperty
  a_reset_offset: assert property (p_reset_offset)
    else $error("Reset did not clear the offset register.");

  property p_reset_alarm_timer;
    @(posedge clock) disable iff (!rst_n)
    s_soft_write |=> (alarmMatchOff == `RSC_ALARM_OFF_RESET) && !countEnable && irqN;
  endproperty
  a_reset_alarm_timer: assert property (p_reset_alarm_timer)
    else $error("Reset left an alarm, the countdown or an interrupt enabled.");

  property p_count_gated;
    @(posedge clock) disable iff (!rst_n)
    (coreReg.ctrl2 & `RSC_CTRL2_WRITE & ~8'h10) == 8'h00 |-> irqN;
  endproperty
  a_count_gated: assert property (p_count_gated)
    else $error("Interrupt pin asserted with every source disabled.");

  property p_minute_tick_flag;
    @(posedge clock) disable iff (!rst_n)
    minuteTick && coreReg.ctrl2[`RSC_C2_LONG_EN] && !softReset
    |=> coreReg.ctrl2[`RSC_C2_TICK_F];
  endproperty
  a_minute_tick_flag: assert property (p_minute_tick_flag)
    else $error("Enabled minute tick did not set the tick flag.");

  property p_alarm_flag_sticky;
    @(posedge clock) disable iff (!rst_n)
    coreReg.ctrl2[`RSC_C2_ALARM_F] && !softReset
    && !(wrEvent && (linkWrAddr == `RSC_ADDR_CTRL2) && !linkWrData[`RSC_C2_ALARM_F])
    |=> coreReg.ctrl2[`RSC_C2_ALARM_F];
  endproperty
  a_alarm_flag_sticky: assert property (p_alarm_flag_sticky)
    else $error("Alarm flag cleared without a zero written to it.");

  property p_pulse_mode_idle;
    @(posedge clock) disable iff (!rst_n)
    coreReg.ctrl2[`RSC_C2_PULSE] && !coreReg.ctrl2[`RSC_C2_ALARM_EN]
    && !$past(tickHit) && !$past(countHit) |-> irqN;
  endproperty
  a_pulse_mode_idle: assert property (p_pulse_mode_idle)
    else $error("Pulse-mode pin asserted without a timer event.");

  property p_alarm_irq;
    @(posedge clock) disable iff (!rst_n)
    coreReg.ctrl2[`RSC_C2_ALARM_F] && coreReg.ctrl2[`RSC_C2_ALARM_EN] |-> !irqN;
  endproperty
  a_alarm_irq: assert property (p_alarm_irq)
    else $error("Enabled alarm flag did not drive the interrupt pin.");
endmodule

// ===== rsc_host_model.sv
// Host controller model that masters the serial link of the block.
`timescale 1ns/10ps
module rsc_host_model (
  output logic      sclk,
  output logic      chipEnable,
  output logic      sdi,
  input  wire logic sdo
);
  // The link clock is parked low and the frame is closed between transfers.
  initial
  begin
    sclk = 1'h0;
    chipEnable = 1'h0;
    sdi = 1'h0;
  end

  // One frame: command byte, then one data byte whose slot also carries the read data (sampled from the tenth edge), cut after n rising edges.
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int n,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    #3 chipEnable = 1'h1;
    for (int i = 0; i < n; i++)
    begin
      sdi = sh[15];
      sh = {sh[14:0], 1'h0};
      #40 sclk = 1'h1;
      if (i >= 9) rd = {rd[6:0], sdo};
      #40 sclk = 1'h0;
    end
    // Hold the frame past the last edge so the core captures the write.
    #40 chipEnable = 1'h0;
    sdi = ~sdi;
    #160;
  endtask
endmodule

// ===== test_rsc_status_reset_control.sv
// Self-checking bench for the status, interrupt and reset control block.
`timescale 1ns/10ps
module test_rsc_status_reset_control;
  logic       clock, rst_n, oscRunning, sclk, chipEnable, sdi, sdo, irqN, halt, clkOn, h12;
  logic       ds, cie, cen, oe;
  logic [3:0] evt, alarmOff;
  logic [2:0] clkSel;
  logic [1:0] cntSrc;
  logic [7:0] offsetWord, rx;
  int         nErrors, numChecks;

  rsc_status_reset_control #(.SETTLE_CYCLES(20)) rsc_status_reset_control_i (
    .clock(clock), .rst_n(rst_n), .sclk(sclk), .chipEnable(chipEnable), .sdi(sdi),
    .sdo(sdo), .sdoOe(oe), .oscRunning(oscRunning), .minuteTick(evt[0]),
    .secondTick(evt[1]), .alarmMatch(evt[2]), .countZero(evt[3]), .irqN(irqN),
    .oscillatorHaltFlag(halt), .clockOutPinEnable(clkOn), .clockOutPinSelect(clkSel),
    .hour12Mode(h12), .dividerStop(ds), .corrIrqEn(cie), .offsetWord(offsetWord),
    .alarmMatchOff(alarmOff), .countEnable(cen), .countSource(cntSrc));
  rsc_host_model rsc_host_model_i (.sclk(sclk), .chipEnable(chipEnable), .sdi(sdi), .sdo(sdo));

  // The core clock runs at 125 MHz.
  initial
  begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  // Compare one value and count it.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    rsc_host_model_i.xfer({4'h0, a}, d, 17, rx);
    @(negedge clock);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    rsc_host_model_i.xfer({4'h4, a}, 8'h00, 17, rx);
    chk(rx, exp);
  endtask
  // One-cycle event pulse: 0 minute, 1 second, 2 alarm, 3 countdown.
  task automatic ev(input int k);
    @(posedge clock) evt <= 4'h1 << k;
    @(posedge clock) evt <= 4'h0;
    repeat (2) @(negedge clock);
  endtask
  task test_done;
    $display("checks %0d, errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    rst_n = 1'h0;
    oscRunning = 1'h0;
    evt = 4'h0;
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    repeat (4) @(negedge clock);
    chk({irqN, halt, clkOn, clkSel, h12, 1'h0}, 8'hE0);
    chk({alarmOff, 2'h0, cntSrc}, 8'hF3);
    chk(offsetWord, 8'h00);
    chk({5'h00, ds, cie, cen}, 8'h00);
    rdc(4'h1, 8'h00);
    rdc(4'hE, 8'h03);
    wr(4'h0, 8'h58);
    wr(4'h2, 8'h00);
    rdc(4'h2, 8'h80);
    @(posedge clock) oscRunning <= 1'h1;
    wr(4'h2, 8'h15);
    rdc(4'h2, 8'h15);
    @(posedge clock) oscRunning <= 1'h0;
    repeat (4) @(negedge clock);
    rdc(4'h2, 8'h95);
    @(posedge clock) oscRunning <= 1'h1;
    wr(4'h9, 8'h25);
    wr(4'hD, 8'h7F);
    rsc_host_model_i.xfer(8'h0D, 8'hFF, 12, rx);
    rdc(4'hD, 8'h7F);
    chk({7'h00, oe}, 8'h00);
    wr(4'h0, 8'h5C);
    chk({7'h00, h12}, 8'h01);
    rdc(4'h0, 8'h04);
    wr(4'h0, 8'h22);
    wr(4'hE, 8'h78);
    chk({clkOn, clkSel, 1'h0, ds, cie, cen}, 8'h77);
    wr(4'h0, 8'h58);
    rdc(4'h0, 8'h00);
    chk({h12, offsetWord[6:0]}, 8'h00);
    chk({clkOn, clkSel, 1'h0, ds, cie, cen}, 8'h80);
    rdc(4'h9, 8'hA5);
    rdc(4'h2, 8'h95);
    wr(4'h1, 8'h02);
    ev(2);
    chk({7'h00, irqN}, 8'h00);
    wr(4'h1, 8'h0A);
    rdc(4'h1, 8'h0A);
    wr(4'h1, 8'h02);
    chk({7'h00, irqN}, 8'h01);
    wr(4'h1, 8'h00);
    ev(2);
    ev(3);
    chk({7'h00, irqN}, 8'h01);
    wr(4'h1, 8'h0D);
    chk({7'h00, irqN}, 8'h00);
    wr(4'h1, 8'h00);
    ev(1);
    rdc(4'h1, 8'h00);
    wr(4'h1, 8'h40);
    ev(1);
    rdc(4'h1, 8'h60);
    chk({7'h00, irqN}, 8'h00);
    wr(4'h1, 8'h80);
    ev(0);
    rdc(4'h1, 8'hA0);
    wr(4'h1, 8'h50);
    @(posedge clock) evt <= 4'h2;
    @(posedge clock) evt <= 4'h0;
    @(negedge clock) chk({7'h00, irqN}, 8'h00);
    @(negedge clock) chk({7'h00, irqN}, 8'h01);
    test_done;
  end

  // Watchdog well beyond the roughly 51 us that the sequence needs.
  initial
  begin
    #400000;
    nErrors++;
    test_done;
  end
endmodule
